// file: rtl/cicyt_defs.vh
`ifndef CICYT_DEFS_VH
`define CICYT_DEFS_VH
// instruction class codes
`define CICYT_OP_SHIFT 5'h00
`define CICYT_OP_MEMSHIFT 5'h01
`define CICYT_OP_MMR 5'h02
`define CICYT_OP_MRM 5'h03
`define CICYT_OP_BCC 5'h04
`define CICYT_OP_DBR 5'h05
`define CICYT_OP_BITREG 5'h06
`define CICYT_OP_BITMEM 5'h07
`define CICYT_OP_JMP 5'h08
`define CICYT_OP_JSR 5'h09
`define CICYT_OP_IMM 5'h0a
`define CICYT_OP_TAS 5'h0b
// bit operation codes
`define CICYT_BIT_CHG 2'h0
`define CICYT_BIT_CLR 2'h1
`define CICYT_BIT_SET 2'h2
`define CICYT_BIT_TST 2'h3
// timing figures in clock periods
`define CICYT_SH_BASE_BW 8'h06
`define CICYT_SH_BASE_L 8'h08
`define CICYT_MEMSH_CLK 8'h08
`define CICYT_MMR_BASE 8'h0c
`define CICYT_MRM_BASE_DISP 8'h0c
`define CICYT_BCC_TAKEN 8'h0a
`define CICYT_BCC_NT_B 8'h08
`define CICYT_BCC_NT_W 8'h0c
`define CICYT_DBR_TRUE 8'h0c
`define CICYT_DBR_BR 8'h0a
`define CICYT_DBR_END 8'h0e
`define CICYT_JMP_CLK 8'h08
`define CICYT_JSR_CLK 8'h10
`define CICYT_IMM_BW 8'h08
`define CICYT_IMM_L 8'h10
`define CICYT_TAS_MEM 8'h0a
`define CICYT_TAS_REG 8'h04
`define CICYT_CLK_PER_BUS 8'h04
`endif

// file: rtl/cicyt_rom.v
`timescale 1ns/10ps
`default_nettype none
// per-entry bit-operation timing table, registered read
module cicyt_rom (
	input wire CLK, // clock
	input wire [2:0] ADDR, // {static, op}
	output reg [15:0] DATA // {clocks, reads, writes}
);
	always @(posedge CLK) begin
		case (ADDR)
			3'h0: DATA <= 16'h0810;
			3'h1: DATA <= 16'h0a10;
			3'h2: DATA <= 16'h0810;
			3'h3: DATA <= 16'h0610;
			3'h4: DATA <= 16'h0c20;
			3'h5: DATA <= 16'h0e20;
			3'h6: DATA <= 16'h0c20;
			default: DATA <= 16'h0a20;
		endcase
	end
endmodule // cicyt_rom
`default_nettype wire

// file: rtl/cicyt_seq.v
// Contract
// - marked forms add effective address clocks, reads and writes to base figures
// - register shift 6+2n or 8+2n long, one read; memory shift 8, 1/1
// - memory-to-register move_multiple: word 12+4n (3+n), long 12+8n (3+2n)
// - long register-to-memory displacement move_multiple: 12+8n, three reads, 2n writes
// - per-register increments scale with count of selected registers
// - cond branch taken 10 (2); not taken 8 (1) byte, 12 (2) word
// - decrement_branch true 12 (2); false branch 10 (2); loop end 14 (3)
// - register bit modify dynamic 8/10 one read; static 12/14 two reads; register bit_test 6 or 10
// - memory bit modify 8 (1/1) dynamic, 12 (2/1) static; bit_test 4 or 8
// - indirect jump 8 with two reads; call 16 with two reads two writes
// - test_and_set memory 10 with locked read-write; register 4, one read
// - counts include operation, writeback and next prefetch
`timescale 1ns/10ps
`default_nettype none
`include "cicyt_defs.vh"
module cicyt_seq (
	input wire CLK, // 25 MHz clock
	input wire RSTN, // async reset, low
	input wire START, // one-cycle instruction request
	input wire [4:0] OP, // instruction class
	input wire LONG, // long size
	input wire MEM, // memory operand
	input wire COND, // branch taken / condition true
	input wire WDISP, // word displacement
	input wire LOOP_END, // decrement_branch counter expired
	input wire STATIC, // static bit number
	input wire [1:0] BITOP, // bit operation
	input wire [5:0] SHIFT_N, // shift count
	input wire [4:0] REG_N, // registers selected, 0..16
	input wire [7:0] EA_CLK, // ea calculation clocks
	input wire [3:0] EA_RD, // ea reads
	input wire [3:0] EA_WR, // ea writes
	input wire BUS_DONE, // bus cycle finished
	output wire BUSY, // instruction in progress
	output reg BUS_RD, // bus read request level
	output reg BUS_WR, // bus write request level
	output reg BUS_LOCK, // indivisible cycle
	output reg DONE, // one-cycle end pulse
	output reg [9:0] CLK_TOTAL, // clocks of last instruction
	output reg [5:0] RD_TOTAL, // reads of last instruction
	output reg [5:0] WR_TOTAL // writes of last instruction
);
	localparam S_IDLE = 4'h1;
	localparam S_LOOK = 4'h2;
	localparam S_RUN = 4'h4;
	localparam S_END = 4'h8;
	reg [3:0] state_q;
	reg [9:0] clk_q, clk_d, cnt_q;
	reg [5:0] rd_q, rd_d, wr_q, wr_d, rd_left_q, wr_left_q;
	reg use_rom_q, ea_q, lock_q, lock_d;
	reg [4:0] op_q;
	reg long_q, mem_q;
	reg [1:0] bit_q;
	reg [7:0] eac_q;
	reg [3:0] ear_q, eaw_q;
	reg bus_done_s1_q, bus_done_q;
	wire [15:0] rom_data;
	wire [9:0] ea_ck;
	cicyt_rom u_rom (
		.CLK(CLK),
		.ADDR({STATIC, BITOP}),
		.DATA(rom_data)
	);
	assign BUSY = (state_q != S_IDLE);
	assign ea_ck = {2'h0, eac_q};
	// base figures from the instruction class
	always @* begin
		clk_d = 10'h000;
		rd_d = 6'h01;
		wr_d = 6'h00;
		lock_d = 1'b0;
		case (OP)
			`CICYT_OP_SHIFT: begin
				clk_d = {2'h0, LONG ? `CICYT_SH_BASE_L : `CICYT_SH_BASE_BW}
					+ {3'h0, SHIFT_N, 1'b0};
			end
			`CICYT_OP_MEMSHIFT: begin
				clk_d = {2'h0, `CICYT_MEMSH_CLK};
				wr_d = 6'h01;
			end
			`CICYT_OP_MMR: begin
				clk_d = {2'h0, `CICYT_MMR_BASE} + (LONG ? {2'h0, REG_N, 3'h0}
					: {3'h0, REG_N, 2'h0});
				rd_d = 6'h03 + (LONG ? {REG_N, 1'b0} : {1'b0, REG_N});
			end
			`CICYT_OP_MRM: begin
				clk_d = {2'h0, `CICYT_MRM_BASE_DISP} + {2'h0, REG_N, 3'h0};
				rd_d = 6'h03;
				wr_d = {REG_N, 1'b0};
			end
			`CICYT_OP_BCC: begin
				if (COND) begin
					clk_d = {2'h0, `CICYT_BCC_TAKEN};
					rd_d = 6'h02;
				end else if (WDISP) begin
					clk_d = {2'h0, `CICYT_BCC_NT_W};
					rd_d = 6'h02;
				end else begin
					clk_d = {2'h0, `CICYT_BCC_NT_B};
				end
			end
			`CICYT_OP_DBR: begin
				rd_d = 6'h02;
				if (COND) begin
					clk_d = {2'h0, `CICYT_DBR_TRUE};
				end else if (LOOP_END) begin
					clk_d = {2'h0, `CICYT_DBR_END};
					rd_d = 6'h03;
				end else begin
					clk_d = {2'h0, `CICYT_DBR_BR};
				end
			end
			`CICYT_OP_JMP: begin
				clk_d = {2'h0, `CICYT_JMP_CLK};
				rd_d = 6'h02;
			end
			`CICYT_OP_JSR: begin
				clk_d = {2'h0, `CICYT_JSR_CLK};
				rd_d = 6'h02;
				wr_d = 6'h02;
			end
			`CICYT_OP_IMM: begin
				clk_d = {2'h0, LONG ? `CICYT_IMM_L : `CICYT_IMM_BW};
				rd_d = LONG ? 6'h03 : 6'h02;
			end
			`CICYT_OP_TAS: begin
				clk_d = {2'h0, MEM ? `CICYT_TAS_MEM : `CICYT_TAS_REG};
				wr_d = MEM ? 6'h01 : 6'h00;
				lock_d = MEM;
			end
			default: begin
				clk_d = 10'h000;
			end
		endcase
	end
	// registered bus_done from memory side
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			bus_done_s1_q <= 1'b0;
			bus_done_q <= 1'b0;
		end else begin
			bus_done_s1_q <= BUS_DONE;
			bus_done_q <= bus_done_s1_q;
		end
	end
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= S_IDLE;
			clk_q <= 10'h000;
			rd_q <= 6'h00;
			wr_q <= 6'h00;
			cnt_q <= 10'h000;
			rd_left_q <= 6'h00;
			wr_left_q <= 6'h00;
			use_rom_q <= 1'b0;
			ea_q <= 1'b0;
			lock_q <= 1'b0;
			op_q <= 5'h00;
			long_q <= 1'b0;
			mem_q <= 1'b0;
			bit_q <= 2'h0;
			eac_q <= 8'h00;
			ear_q <= 4'h0;
			eaw_q <= 4'h0;
			BUS_RD <= 1'b0;
			BUS_WR <= 1'b0;
			BUS_LOCK <= 1'b0;
			DONE <= 1'b0;
			CLK_TOTAL <= 10'h000;
			RD_TOTAL <= 6'h00;
			WR_TOTAL <= 6'h00;
		end else begin
			DONE <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (START) begin
						clk_q <= clk_d;
						rd_q <= rd_d;
						wr_q <= wr_d;
						lock_q <= lock_d;
						op_q <= OP;
						long_q <= LONG;
						mem_q <= MEM;
						bit_q <= BITOP;
						use_rom_q <= (OP == `CICYT_OP_BITREG) || (OP == `CICYT_OP_BITMEM);
						// ea-marked forms: memory shift, memory bit ops, memory tas
						ea_q <= (OP == `CICYT_OP_MEMSHIFT) || (OP == `CICYT_OP_BITMEM)
							|| ((OP == `CICYT_OP_TAS) && MEM);
						eac_q <= EA_CLK;
						ear_q <= EA_RD;
						eaw_q <= EA_WR;
						state_q <= S_LOOK;
					end
				end
				S_LOOK: begin
					if (use_rom_q) begin
						if (op_q == `CICYT_OP_BITREG) begin
							clk_q <= {2'h0, rom_data[15:8]};
							rd_q <= {2'h0, rom_data[7:4]};
							wr_q <= 6'h00;
						end else if (bit_q == `CICYT_BIT_TST) begin
							// static entries are the ones that owe two reads
							clk_q <= rom_data[5] ? 10'h008 : 10'h004;
							rd_q <= {2'h0, rom_data[7:4]};
							wr_q <= 6'h00;
						end else begin
							clk_q <= rom_data[5] ? 10'h00c : 10'h008;
							rd_q <= {2'h0, rom_data[7:4]};
							wr_q <= 6'h01;
						end
					end else if (ea_q) begin
						clk_q <= clk_q + ea_ck;
						rd_q <= rd_q + {2'h0, ear_q};
						wr_q <= wr_q + {2'h0, eaw_q};
					end
					state_q <= S_RUN;
					cnt_q <= 10'h000;
				end
				S_RUN: begin
					if (cnt_q == 10'h000 && use_rom_q && op_q == `CICYT_OP_BITMEM) begin
						clk_q <= clk_q + ea_ck;
						rd_q <= rd_q + {2'h0, ear_q};
						wr_q <= wr_q + {2'h0, eaw_q};
						rd_left_q <= rd_q + {2'h0, ear_q};
						wr_left_q <= wr_q + {2'h0, eaw_q};
					end else if (cnt_q == 10'h000) begin
						rd_left_q <= rd_q;
						wr_left_q <= wr_q;
					end
					cnt_q <= cnt_q + 10'h001;
					// reads first, then writes; lock spans tas pair
					BUS_RD <= (cnt_q != 10'h000) && (rd_left_q != 6'h00);
					BUS_WR <= (cnt_q != 10'h000) && (rd_left_q == 6'h00)
						&& (wr_left_q != 6'h00);
					BUS_LOCK <= lock_q && (cnt_q != 10'h000)
						&& ((rd_left_q != 6'h00) || (wr_left_q != 6'h00));
					if (cnt_q != 10'h000 && bus_done_q) begin
						if (rd_left_q != 6'h00)
							rd_left_q <= rd_left_q - 6'h01;
						else if (wr_left_q != 6'h00)
							wr_left_q <= wr_left_q - 6'h01;
					end
					// count spans operation, writeback and prefetch; a slow bus stretches
					// the run until every owed cycle is retired
					if (cnt_q + 10'h001 >= clk_q && cnt_q != 10'h000
						&& rd_left_q == 6'h00 && wr_left_q == 6'h00) begin
						state_q <= S_END;
					end
				end
				S_END: begin
					BUS_RD <= 1'b0;
					BUS_WR <= 1'b0;
					BUS_LOCK <= 1'b0;
					DONE <= 1'b1;
					CLK_TOTAL <= clk_q;
					RD_TOTAL <= rd_q;
					WR_TOTAL <= wr_q;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule // cicyt_seq
`default_nettype wire

// file: dv/cicyt_mem.sv
`timescale 1ns/10ps
`default_nettype none
// memory side: one bus cycle at a time, answering at once, then a variable wait before the next
module cicyt_mem (
	input wire logic clk, // clock
	input wire logic rstn, // reset, low
	input wire logic rd, // read request
	input wire logic wr, // write request
	input wire logic [2:0] lat, // extra wait
	output var logic done, // cycle finished
	output var int n_rd, // reads served
	output var int n_wr // writes served
);
	int w;
	// the gap covers the request's slow release through the done synchroniser
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			done <= 1'b0;
			w <= 0;
			n_rd <= 0;
			n_wr <= 0;
		end else if (w > 0) begin
			done <= 1'b0;
			w <= w - 1;
		end else if (rd || wr) begin
			done <= 1'b1;
			n_rd <= n_rd + int'(rd);
			n_wr <= n_wr + int'(wr);
			w <= 4 + int'(lat);
		end else begin
			done <= 1'b0;
		end
	end
endmodule // cicyt_mem
`default_nettype wire

// file: dv/cicyt_seq_sva.sv
`timescale 1ns/10ps
`default_nettype none
module cicyt_seq_sva (
	input wire CLK, // clock
	input wire RSTN, // reset, low
	input wire START, // request
	input wire BUSY, // in progress
	input wire BUS_RD, // read level
	input wire BUS_WR, // write level
	input wire BUS_LOCK, // locked cycle
	input wire DONE, // end pulse
	input wire [9:0] CLK_TOTAL, // clocks
	input wire [5:0] RD_TOTAL, // reads
	input wire [5:0] WR_TOTAL // writes
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence s_take;
		START && !BUSY;
	endsequence
	sequence s_end;
		!BUSY ##1 !DONE;
	endsequence
	take_busy_a: assert property (s_take |=> BUSY)
		else $error("start not taken");
	take_min_a: assert property (s_take |=> !DONE [*3])
		else $error("end too early");
	end_idle_a: assert property (DONE |-> s_end)
		else $error("busy after end");
	bus_excl_a: assert property (!(BUS_RD && BUS_WR))
		else $error("read and write together");
	rd_after_wr_a: assert property (BUS_WR |=> !BUS_RD)
		else $error("read after write");
	idle_quiet_a: assert property (!BUSY |-> !BUS_RD && !BUS_WR)
		else $error("bus request while idle");
	lock_busy_a: assert property (BUS_LOCK |-> BUSY)
		else $error("lock outside instruction");
	totals_hold_a: assert property (!DONE |-> $stable({CLK_TOTAL, RD_TOTAL, WR_TOTAL}))
		else $error("totals moved without end");
	bus_time_a: assert property (DONE |->
		CLK_TOTAL >= ({4'h0, RD_TOTAL} + {4'h0, WR_TOTAL}) * 10'h004)
		else $error("clocks below bus time");
endmodule // cicyt_seq_sva
bind cicyt_seq cicyt_seq_sva u_sva (.CLK(CLK), .RSTN(RSTN), .START(START), .BUSY(BUSY),
	.BUS_RD(BUS_RD), .BUS_WR(BUS_WR), .BUS_LOCK(BUS_LOCK), .DONE(DONE),
	.CLK_TOTAL(CLK_TOTAL), .RD_TOTAL(RD_TOTAL), .WR_TOTAL(WR_TOTAL));
`default_nettype wire

// file: dv/test_cicyt_seq.sv
`timescale 1ns/10ps
`default_nettype none
module test_cicyt_seq;
	logic clk, rstn, start, lg, mm, cd, wd, le, st, bdone, busy, brd, bwr, block, done;
	logic [4:0] op, rn;
	logic [1:0] bo;
	logic [5:0] sn, rt, wt;
	logic [7:0] ec;
	logic [3:0] er, ew;
	logic [9:0] ct;
	logic [2:0] lat;
	logic [21:0] e;
	int n_fail, total_checks, nr, nw, r0, w0, k, j, lk;
	logic sw;
	cicyt_seq u_dut (.CLK(clk), .RSTN(rstn), .START(start), .OP(op), .LONG(lg), .MEM(mm),
		.COND(cd), .WDISP(wd), .LOOP_END(le), .STATIC(st), .BITOP(bo), .SHIFT_N(sn),
		.REG_N(rn), .EA_CLK(ec), .EA_RD(er), .EA_WR(ew), .BUS_DONE(bdone), .BUSY(busy),
		.BUS_RD(brd), .BUS_WR(bwr), .BUS_LOCK(block), .DONE(done), .CLK_TOTAL(ct),
		.RD_TOTAL(rt), .WR_TOTAL(wt));
	cicyt_mem u_mem (.clk(clk), .rstn(rstn), .rd(brd), .wr(bwr), .lat(lat), .done(bdone),
		.n_rd(nr), .n_wr(nw));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// expected {clocks, reads, writes} of the instruction now on the inputs
	function automatic logic [21:0] exp_t();
		int c, r, w, a;
		r = 1;
		w = 0;
		a = 0;
		case (op)
			5'h00: c = (lg ? 8 : 6) + 2 * sn;
			5'h01: {c, w, a} = {32'd8, 32'd1, 32'd1};
			5'h02: {c, r} = {int'(12 + (lg ? 8 : 4) * rn), int'(3 + (lg ? 2 : 1) * rn)};
			5'h03: {c, r, w} = {int'(12 + 8 * rn), 32'd3, int'(2 * rn)};
			5'h04: {c, r} = {int'(cd ? 10 : wd ? 12 : 8), int'((cd || wd) ? 2 : 1)};
			5'h05: {c, r} = {int'(cd ? 12 : le ? 14 : 10), int'((!cd && le) ? 3 : 2)};
			5'h06: {c, r} = {int'((st ? 12 : 8) + (bo == 2'h1 ? 2 : 0)), int'(st ? 2 : 1)};
			5'h07: {c, r, w, a} = {int'((st ? 12 : 8) - (bo == 2'h3 ? 4 : 0)), int'(st ? 2 : 1),
				int'(bo != 2'h3), 32'd1};
			5'h08: {c, r} = {32'd8, 32'd2};
			5'h09: {c, r, w} = {32'd16, 32'd2, 32'd2};
			5'h0a: {c, r} = {int'(lg ? 16 : 8), int'(lg ? 3 : 2)};
			default: {c, w, a} = {int'(mm ? 10 : 4), int'(mm), int'(mm)};
		endcase
		if (a != 0) begin
			c = c + ec;
			r = r + er;
			w = w + ew;
		end
		return {c[9:0], r[5:0], w[5:0]};
	endfunction
	task automatic finish_test;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [21:0] got, input string m);
		total_checks++;
		if (got !== e) begin
			n_fail++;
			$display("BAD %0t %s op %h got %h exp %h", $time, m, op, got, e);
		end
	endtask
	// one instruction; cn forces boundary counts, ag retries start while busy
	task automatic run(input logic [4:0] o, input bit cn, input bit ag);
		@(negedge clk);
		op = o;
		{lg, mm, cd, wd, le, st} = 6'($urandom) | {(o == 5'h03 || cn), 5'h00};
		bo = (o == 5'h06) ? 2'($urandom % 3) : 2'($urandom);
		sn = cn ? 6'h3f : 6'($urandom);
		rn = cn ? 5'h10 : 5'($urandom % 17);
		er = 4'($urandom % 4);
		ew = 4'($urandom % 2);
		ec = 8'(4 * (er + ew) + 2 * ($urandom % 4));
		lat = 3'($urandom);
		e = exp_t();
		r0 = nr;
		w0 = nw;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		if (ag) begin
			@(negedge clk);
			start = 1'b1;
			@(negedge clk);
			start = 1'b0;
		end
		k = 0;
		lk = 0;
		sw = 1'b0;
		while (done !== 1'b1 && k < 3000) begin
			@(posedge clk);
			#1;
			k++;
			if (bwr === 1'b1) sw = 1'b1;
			if ((brd !== 1'b0 && sw) || (block !== ((brd || bwr) && o == 5'h0b && mm))) lk++;
		end
		if (k >= 3000) begin
			n_fail++;
			$display("BAD %0t no end pulse op %h", $time, op);
			finish_test;
		end
		chk({ct, rt, wt}, "totals");
		chk({ct, 6'(nr - r0), 6'(nw - w0)}, "bus cycles");
		total_checks++;
		if (lk != 0) begin
			n_fail++;
			$display("BAD %0t lock or bus order fault op %h", $time, op);
		end
	endtask
	initial begin
		{rstn, start, lg, mm, cd, wd, le, st, bo, op, sn, rn, ec, er, ew, lat} = '0;
		n_fail = 0;
		total_checks = 0;
		j = $urandom(67879);
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		for (j = 0; j < 12; j++) run(5'(j), 1'b1, 1'b0);
		for (j = 0; j < 300; j++) run(5'($urandom % 12), 1'b0, 1'($urandom));
		finish_test;
	end
	initial begin
		// well above the expected run of about 20000 cycles
		#(40 * 60000);
		n_fail++;
		finish_test;
	end
endmodule // test_cicyt_seq
`default_nettype wire
